// file: core/claim_lock_pkg.sv
// Constants, types and decode helpers for the claim tag and software lock registers
package claim_lock_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int TAG_W = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CLAIM_SET = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CLAIM_CLEAR = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_LOCK_ACCESS = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_LOCK_STATUS = 12'h00C;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions and values
  localparam int STATUS_PRESENT_BIT = 0;
  localparam int STATUS_LOCKED_BIT = 1;
  localparam int STATUS_WIDTH_BIT = 2;
  localparam logic [DATA_W-1:0] UNLOCK_KEY = 32'hC5ACCE55;
  localparam logic [STRB_W-1:0] FULL_STRB = 4'hF;
  localparam logic [TAG_W-1:0] TAG_IMPL = 4'hF;
  localparam logic [TAG_W-1:0] TAG_RESET = 4'h0;
  localparam logic LOCK_RESET = 1'b1;
  localparam logic LOCK_PRESENT_ONCHIP = 1'b1;
  localparam logic LOCK_WIDTH_32 = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    REG_CLAIM_SET,
    REG_CLAIM_CLEAR,
    REG_LOCK_ACCESS,
    REG_LOCK_STATUS,
    REG_NONE
  } reg_sel_t;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'h0,
    WR_APPLY = 2'h1,
    WR_RESP = 2'h3
  } wr_state_t;

  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } rd_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic from_debug;
  } addr_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [STRB_W-1:0] strb;
  } wdata_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Word-aligned address decode
  function automatic reg_sel_t decode_reg(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] word;
    word = {addr[ADDR_W-1:2], 2'h0};
    if (word == OFS_CLAIM_SET) begin
      return REG_CLAIM_SET;
    end else if (word == OFS_CLAIM_CLEAR) begin
      return REG_CLAIM_CLEAR;
    end else if (word == OFS_LOCK_ACCESS) begin
      return REG_LOCK_ACCESS;
    end else if (word == OFS_LOCK_STATUS) begin
      return REG_LOCK_STATUS;
    end
    return REG_NONE;
  endfunction

endpackage

// file: core/claim_tag_store.sv
// Four-bit claim tag storage with set and clear masks
`timescale 1ns/1ns

module claim_tag_store
  import claim_lock_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Update strobes
  input wire logic set_en,
  input wire logic clear_en,
  input wire logic [TAG_W-1:0] mask,
  // Stored tag
  output logic [TAG_W-1:0] tag
);

  ////////////////////////////////////////////////////////////////////////////////
  // Tag flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tag <= TAG_RESET;
    end else if (set_en) begin
      tag <= tag | (mask & TAG_IMPL);
    end else if (clear_en) begin
      tag <= tag & ~mask;
    end
  end

endmodule

// file: core/claim_lock_regs.sv
// AXI4-Lite register bank for the claim tag and software write lock
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ns

module claim_lock_regs
  import claim_lock_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic aw_from_debug,
  // Write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [STRB_W-1:0] wstrb,
  // Write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic ar_from_debug,
  // Read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // Status
  output logic [TAG_W-1:0] claim_tag,
  output logic sw_locked
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  wr_state_t wr_state;
  rd_state_t rd_state;
  addr_req_t wr_addr;
  wdata_t wr_word;
  logic have_aw;
  logic have_w;
  logic aw_take;
  logic w_take;
  logic ar_take;
  reg_sel_t wr_sel;
  reg_sel_t rd_sel;
  logic wr_blocked;
  logic tag_set_en;
  logic tag_clear_en;
  logic [TAG_W-1:0] tag_mask;
  logic lock_write;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0] next_rresp;
  logic [1:0] next_bresp;
  logic unused_prot;

  assign aw_take = awvalid && awready;
  assign w_take = wvalid && wready;
  assign ar_take = arvalid && arready;
  assign unused_prot = ^{awprot, arprot};

  ////////////////////////////////////////////////////////////////////////////////
  // Write channel capture
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awready <= 1'b1;
      have_aw <= 1'b0;
      wr_addr <= '0;
    end else if (aw_take) begin
      awready <= 1'b0;
      have_aw <= 1'b1;
      wr_addr <= '{addr: awaddr, from_debug: aw_from_debug};
    end else if (wr_state == WR_RESP && bready) begin
      awready <= 1'b1;
      have_aw <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wready <= 1'b1;
      have_w <= 1'b0;
      wr_word <= '0;
    end else if (w_take) begin
      wready <= 1'b0;
      have_w <= 1'b1;
      wr_word <= '{data: wdata, strb: wstrb};
    end else if (wr_state == WR_RESP && bready) begin
      wready <= 1'b1;
      have_w <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write sequencing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_state <= WR_COLLECT;
    end else begin
      unique case (wr_state)
        WR_COLLECT: begin
          if (have_aw && have_w) begin
            wr_state <= WR_APPLY;
          end
        end
        WR_APPLY: begin
          wr_state <= WR_RESP;
        end
        WR_RESP: begin
          if (bready) begin
            wr_state <= WR_COLLECT;
          end
        end
        default: begin
          wr_state <= WR_COLLECT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write decode and lock gating
  always_comb begin
    wr_sel = decode_reg(wr_addr.addr);
    wr_blocked = sw_locked && !wr_addr.from_debug;
    tag_mask = wr_word.data[TAG_W-1:0];
    tag_set_en = 1'b0;
    tag_clear_en = 1'b0;
    lock_write = 1'b0;
    next_bresp = RESP_OKAY;
    if (wr_state == WR_APPLY) begin
      unique case (wr_sel)
        REG_CLAIM_SET: begin
          tag_set_en = !wr_blocked && wr_word.strb[0];
        end
        REG_CLAIM_CLEAR: begin
          // only the low tag bits act
          tag_clear_en = !wr_blocked && wr_word.strb[0];
        end
        REG_LOCK_ACCESS: begin
          // no lock exists on the debugger path
          lock_write = !wr_addr.from_debug && LOCK_PRESENT_ONCHIP;
        end
        REG_LOCK_STATUS: begin
          // Read-only: write accepted, no effect
          next_bresp = RESP_OKAY;
        end
        REG_NONE: begin
          next_bresp = RESP_SLVERR;
        end
        default: begin
          next_bresp = RESP_SLVERR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software lock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sw_locked <= LOCK_RESET;
    end else if (lock_write) begin
      if (wr_word.data == UNLOCK_KEY && wr_word.strb == FULL_STRB) begin
        sw_locked <= 1'b0;
      end else begin
        sw_locked <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write response
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_state == WR_APPLY) begin
      bvalid <= 1'b1;
      bresp <= next_bresp;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Claim tag storage
  // tag feeds only readback and status
  claim_tag_store u_claim_tag_store (
    .clk(clk),
    .resetn(resetn),
    .set_en(tag_set_en),
    .clear_en(tag_clear_en),
    .mask(tag_mask),
    .tag(claim_tag)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Read data select
  always_comb begin
    rd_sel = decode_reg(araddr);
    next_rdata = '0;
    next_rresp = RESP_OKAY;
    unique case (rd_sel)
      REG_CLAIM_SET: begin
        next_rdata[TAG_W-1:0] = TAG_IMPL;
      end
      REG_CLAIM_CLEAR: begin
        next_rdata[TAG_W-1:0] = claim_tag;
      end
      REG_LOCK_ACCESS: begin
        next_rdata = '0;
      end
      REG_LOCK_STATUS: begin
        if (!ar_from_debug) begin
          next_rdata[STATUS_WIDTH_BIT] = LOCK_WIDTH_32;
          next_rdata[STATUS_LOCKED_BIT] = sw_locked;
          next_rdata[STATUS_PRESENT_BIT] = LOCK_PRESENT_ONCHIP;
        end
      end
      REG_NONE: begin
        next_rresp = RESP_SLVERR;
      end
      default: begin
        next_rresp = RESP_SLVERR;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_state <= RD_IDLE;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      unique case (rd_state)
        RD_IDLE: begin
          if (ar_take) begin
            rd_state <= RD_RESP;
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= next_rresp;
          end
        end
        RD_RESP: begin
          if (rready) begin
            rd_state <= RD_IDLE;
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
          end
        end
      endcase
    end
  end

endmodule

// file: dv/claim_lock_regs_chk.sv
// Concurrent checks on the claim tag and lock register ports
`timescale 1ns/1ns
module claim_lock_regs_chk
  import claim_lock_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Write side
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic aw_from_debug,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [STRB_W-1:0] wstrb,
  input wire logic bvalid,
  // Read side
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic ar_from_debug,
  input wire logic rvalid,
  input wire logic [DATA_W-1:0] rdata,
  // Status
  input wire logic [TAG_W-1:0] claim_tag,
  input wire logic sw_locked
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic wr_take;
  logic rd_take;
  logic key_ok;
  logic [TAG_W-1:0] wtag;
  assign wr_take = awvalid && awready && wvalid && wready;
  assign rd_take = arvalid && arready;
  assign key_ok = wdata == 32'hC5ACCE55 && wstrb == 4'hF;
  assign wtag = wdata[TAG_W-1:0];
  sequence s_lock_wr;
    wr_take && !aw_from_debug && awaddr == OFS_LOCK_ACCESS;
  endsequence
  sequence s_resp_wait;
    !bvalid ##1 !bvalid ##1 bvalid;
  endsequence
  a_rd_answer: assert property (rd_take |=> rvalid)
    else $error("read answer late");
  a_wr_answer: assert property (wr_take |=> s_resp_wait)
    else $error("write answer timing");
  a_status_chip: assert property (rd_take && !ar_from_debug && araddr == OFS_LOCK_STATUS
    |=> rdata == {29'h0, 1'b0, $past(sw_locked), 1'b1})
    else $error("on-chip status wrong");
  a_status_dbg: assert property (rd_take && ar_from_debug && araddr == OFS_LOCK_STATUS
    |=> rdata == 32'h0)
    else $error("debugger status not zero");
  a_clear_read: assert property (rd_take && araddr == OFS_CLAIM_CLEAR
    |=> rdata == {28'h0, $past(claim_tag)})
    else $error("tag readback wrong");
  a_set_read: assert property (rd_take && araddr == OFS_CLAIM_SET |=> rdata == 32'hF)
    else $error("implemented tag bits wrong");
  a_lock_key: assert property (s_lock_wr |-> ##3 sw_locked == !$past(key_ok, 3))
    else $error("lock state after key write");
  a_locked_quiet: assert property (wr_take && !aw_from_debug && sw_locked
    && awaddr != OFS_LOCK_ACCESS |=> $stable(claim_tag) [*3])
    else $error("locked write took effect");
  a_state_cause: assert property ($changed(claim_tag) || $changed(sw_locked)
    |-> $rose(bvalid))
    else $error("state moved without write");
  a_debug_free: assert property (wr_take && aw_from_debug && awaddr == OFS_CLAIM_SET
    && wstrb[0] |-> ##3 (claim_tag & $past(wtag, 3)) == $past(wtag, 3))
    else $error("debugger claim set blocked");
  a_clear_bits: assert property (wr_take && awaddr == OFS_CLAIM_CLEAR && wstrb[0]
    && (aw_from_debug || !sw_locked) |-> ##3 (claim_tag & $past(wtag, 3)) == 4'h0)
    else $error("claim clear missed bits");
endmodule

bind claim_lock_regs claim_lock_regs_chk i_chk (
  .clk(clk),
  .resetn(resetn),
  .awvalid(awvalid),
  .awready(awready),
  .awaddr(awaddr),
  .aw_from_debug(aw_from_debug),
  .wvalid(wvalid),
  .wready(wready),
  .wdata(wdata),
  .wstrb(wstrb),
  .bvalid(bvalid),
  .arvalid(arvalid),
  .arready(arready),
  .araddr(araddr),
  .ar_from_debug(ar_from_debug),
  .rvalid(rvalid),
  .rdata(rdata),
  .claim_tag(claim_tag),
  .sw_locked(sw_locked)
);

// file: dv/axil_master_model.sv
// Register bus master standing for on-chip software and the debugger path
`timescale 1ns/1ns
module axil_master_model
  import claim_lock_pkg::*;
(
  // Clock
  input wire logic clk,
  // Write side
  output logic awvalid,
  input wire logic awready,
  output logic [ADDR_W-1:0] awaddr,
  output logic [2:0] awprot,
  output logic aw_from_debug,
  output logic wvalid,
  input wire logic wready,
  output logic [DATA_W-1:0] wdata,
  output logic [STRB_W-1:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  // Read side
  output logic arvalid,
  input wire logic arready,
  output logic [ADDR_W-1:0] araddr,
  output logic [2:0] arprot,
  output logic ar_from_debug,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awvalid, awaddr, awprot, aw_from_debug, wvalid, wdata, wstrb, bready} <= '0;
    {arvalid, araddr, arprot, ar_from_debug, rready} <= '0;
  end
  task automatic wr(input logic [11:0] a, input logic d, input logic [31:0] v,
                    input logic [3:0] s);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    aw_from_debug <= d;
    wvalid <= 1'b1;
    wdata <= v;
    wstrb <= s;
    bready <= 1'b1;
    fork
      begin
        do @(posedge clk); while (!awready);
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      begin
        do @(posedge clk); while (!wready);
        wvalid <= 1'b0;
        wdata <= ~v;
      end
    join
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic d);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    ar_from_debug <= d;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
  endtask
endmodule

// file: dv/claim_tag_and_software_lock_tb_top.sv
// Self-checking bench for the claim tag and lock register bank
`timescale 1ns/1ns
module claim_tag_and_software_lock_tb_top
  import claim_lock_pkg::*;
;
  localparam logic ONC = 1'b0;
  localparam logic DBG = 1'b1;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic awvalid, awready, aw_from_debug, wvalid, wready, bvalid, bready;
  logic arvalid, arready, ar_from_debug, rvalid, rready, sw_locked;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [DATA_W-1:0] wdata, rdata, v;
  logic [STRB_W-1:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [TAG_W-1:0] claim_tag, tag;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [31:0] seed = 32'h0001443B;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  claim_lock_regs i_dut (
    .clk(clk), .resetn(resetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
    .aw_from_debug(aw_from_debug),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
    .ar_from_debug(ar_from_debug),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .claim_tag(claim_tag), .sw_locked(sw_locked)
  );
  axil_master_model i_master (
    .clk(clk),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
    .aw_from_debug(aw_from_debug),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
    .ar_from_debug(ar_from_debug), .rvalid(rvalid), .rready(rready)
  );
  initial begin
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic note(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_b(input logic [1:0] got);
    note({32'h0, got}, {32'h0, bq.pop_front()});
  endtask
  task automatic cmp_r(input logic [33:0] got);
    note(got, rq.pop_front());
  endtask
  task automatic wrc(input logic [11:0] a, input logic d, input logic [31:0] x,
                     input logic [3:0] s, input logic [1:0] r = RESP_OKAY);
    bq.push_back(r);
    i_master.wr(a, d, x, s);
  endtask
  task automatic rdc(input logic [11:0] a, input logic d, input logic [31:0] e,
                     input logic [1:0] r = RESP_OKAY);
    rq.push_back({r, e});
    i_master.rd(a, d);
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (bvalid && bready) begin
      cmp_b(bresp);
    end
    if (rvalid && rready) begin
      cmp_r({rresp, rdata});
    end
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rdc(OFS_LOCK_STATUS, ONC, 32'h3);
    rdc(OFS_LOCK_STATUS, DBG, 32'h0);
    rdc(OFS_CLAIM_SET, ONC, 32'hF);
    wrc(OFS_CLAIM_SET, ONC, 32'hF, 4'hF);
    rdc(OFS_CLAIM_CLEAR, ONC, 32'h0);
    wrc(OFS_CLAIM_SET, DBG, 32'hF, 4'hF);
    rdc(OFS_CLAIM_CLEAR, DBG, 32'hF);
    wrc(OFS_LOCK_ACCESS, ONC, 32'hC5ACCE55, 4'h7);
    rdc(OFS_LOCK_STATUS, ONC, 32'h3);
    wrc(OFS_LOCK_ACCESS, DBG, 32'hC5ACCE55, 4'hF);
    rdc(OFS_LOCK_STATUS, ONC, 32'h3);
    wrc(OFS_LOCK_ACCESS, ONC, 32'hC5ACCE55, 4'hF);
    rdc(OFS_LOCK_STATUS, ONC, 32'h1);
    tag = 4'hF;
    repeat (16) begin
      v = rnd();
      wrc(OFS_CLAIM_CLEAR, ONC, v, 4'hF);
      tag &= ~v[3:0];
      rdc(OFS_CLAIM_CLEAR, ONC, {28'h0, tag});
      v = rnd();
      wrc(OFS_CLAIM_SET, ONC, v, 4'hF);
      tag |= v[3:0];
      rdc(OFS_LOCK_STATUS, ONC, 32'h1);
    end
    v = rnd();
    wrc(OFS_LOCK_ACCESS, ONC, v, 4'hF);
    wrc(OFS_CLAIM_CLEAR, ONC, 32'hF, 4'hF);
    rdc(OFS_CLAIM_CLEAR, ONC, {28'h0, tag});
    rdc(OFS_LOCK_STATUS, ONC, (v == 32'hC5ACCE55) ? 32'h1 : 32'h3);
    wrc(12'h010, ONC, v, 4'hF, RESP_SLVERR);
    rdc(12'h010, DBG, 32'h0, RESP_SLVERR);
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule
